// ===== tb/dmc_channel_ctl_bench.sv
// Self-checking bench for the channel control block.
`timescale 1ns/1ns
`include "dmc_consts.vh"
module dmc_channel_ctl_bench;
   logic clk, rst, awv, wv, bready, arv, rready, req, esc;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdv, cnt;
   logic [1:0] resp, a;
   logic [15:0] b;
   logic [3:0] strb;
   wire awready, wready, bvalid, arready, rvalid, active, ack, serr, esc_irq, cnt_irq;
   wire [1:0] bresp, rresp, acc, mode;
   wire [31:0] rdata;
   integer errors = 0, check_count = 0, seed = 32'h203dd5f2, i, m, n;

   dmc_channel_ctl u_dut (.MCLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .XFER_REQ(req), .ESC_EVENT(esc), .CHAN_ACTIVE(active),
      .ACC_SIZE(acc), .XFER_MODE(mode), .XFER_ACK(ack), .SIZE_ERR(serr),
      .ESC_IRQ(esc_irq), .CNT_IRQ(cnt_irq));

   // Free running clock at 100 MHz.
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // Readiness is sampled at the falling edge so the rising edge decision never races.
   task wr(input logic [7:0] ad, input logic [31:0] d);
      logic ta, tw, bv;
      @(posedge clk);
      awaddr <= ad; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
      forever begin
         @(negedge clk);
         ta = awv && awready; tw = wv && wready; bv = bvalid; resp = bresp;
         @(posedge clk);
         if (ta) awv <= 0;
         if (tw) wv <= 0;
         if (bv) break;
      end
      bready <= 0;
      @(negedge clk);
   endtask

   task rd(input logic [7:0] ad);
      logic ta, rv;
      @(posedge clk);
      araddr <= ad; arv <= 1; rready <= 1;
      forever begin
         @(negedge clk);
         ta = arv && arready; rv = rvalid; rdv = rdata; resp = rresp;
         @(posedge clk);
         if (ta) arv <= 0;
         if (rv) break;
      end
      rready <= 0;
      @(negedge clk);
   endtask

   // One request pulse, then the answer pulses are looked at in their only cycle.
   task xfer(input logic ea, input logic ee);
      @(posedge clk) req <= 1;
      @(posedge clk) req <= 0;
      @(negedge clk);
      chk(ack, ea, "ack");
      chk(serr, ee, "size error");
   endtask

   // Mode word from flags, fields and the enables {size error, escape, count end}.
   function logic [31:0] mw(input logic [1:0] f, s, md, input logic [2:0] en);
      mw = {14'h0, f, s, md, en[2], 1'b0, en[1:0], 8'h00};
   endfunction

   function logic [31:0] amt(input logic [1:0] s, md, input logic [15:0] bs);
      amt = (md == `DMC_MODE_BLOCK ? {16'h0, bs} : 32'h1) << s;
   endfunction

   task complete_run;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // The tests take a few hundred cycles; this bound only catches a hang.
   initial begin
      #500000;
      errors++;
      complete_run;
   end

   initial begin
      {awv, wv, bready, arv, rready, req, esc} = 0;
      awaddr = 0; araddr = 0; wdata = 0; strb = 4'hf; rst = 1;
      repeat (16) @(posedge clk);
      rst <= 0;
      rd(`DMC_OFS_MODE_CTL);
      chk(rdv, 0, "mode reset");
      rd(`DMC_OFS_BLOCK);
      chk(rdv, 1, "block reset");
      rd(8'h10);
      chk(rdv, 0, "unmapped read data");
      chk(resp, `DMC_RESP_SLVERR, "unmapped read response");
      wr(8'h10, 32'hffff_ffff);
      chk(resp, `DMC_RESP_SLVERR, "unmapped write response");
      // Only the low byte lane is enabled, so the upper lanes keep their old value.
      @(posedge clk) strb <= 4'h1;
      wr(`DMC_OFS_BLOCK, 32'h0000_ff07);
      chk(resp, `DMC_RESP_OKAY, "mapped write response");
      @(posedge clk) strb <= 4'hf;
      rd(`DMC_OFS_BLOCK);
      chk(rdv, 32'h0000_0007, "byte lane write");
      // All ones except the two code fields, which software must never set to 11.
      wr(`DMC_OFS_MODE_CTL, 32'hffff_afff);
      rd(`DMC_OFS_MODE_CTL);
      chk(rdv, mw(0, `DMC_ACC_LONG, `DMC_MODE_REPEAT, 3'b111), "reserved bit");
      for (i = 0; i < 9; i++) begin
         a = i % 3;
         n = i / 3;
         wr(`DMC_OFS_MODE_CTL, mw(0, a, n, 0));
         chk({acc, mode}, {a, n[1:0]}, "fields");
      end
      $display("test registers done");
      for (i = 0; i < 4; i++) begin
         a = {$random(seed)} % 3;
         n = {$random(seed)} % 3 + 1;
         wr(`DMC_OFS_MODE_CTL, mw(0, a, `DMC_MODE_NORMAL, 3'b001));
         wr(`DMC_OFS_COUNT, n << a);
         wr(`DMC_OFS_RUN_CTL, 1);
         repeat (n) xfer(1, 0);
         chk({active, cnt_irq}, 2'b01, "count end");
         xfer(0, 0);
         wr(`DMC_OFS_MODE_CTL, mw(2'b01, a, 0, 3'b000));
         chk(cnt_irq, 0, "count irq masked");
         wr(`DMC_OFS_MODE_CTL, mw(2'b01, a, 0, 3'b001));
         chk(cnt_irq, 1, "count irq unmasked");
         if (i[0]) begin
            wr(`DMC_OFS_RUN_CTL, 1);
            chk(cnt_irq, 0, "start clears flag");
            wr(`DMC_OFS_RUN_CTL, 0);
         end else begin
            wr(`DMC_OFS_MODE_CTL, mw(0, a, 0, 3'b001));
            chk(cnt_irq, 1, "clear without read");
            rd(`DMC_OFS_MODE_CTL);
            chk(rdv[16], 1, "flag read");
            wr(`DMC_OFS_MODE_CTL, mw(0, a, 0, 3'b001));
            chk(cnt_irq, 0, "clear after read");
         end
      end
      $display("test count end done");
      for (m = 0; m < 3; m++) begin
         a = 1 + {$random(seed)} % 2;
         b = 2 + {$random(seed)} % 3;
         cnt = amt(a, m, b);
         wr(`DMC_OFS_BLOCK, {16'h0, b});
         wr(`DMC_OFS_MODE_CTL, mw(0, a, m, 3'b110));
         wr(`DMC_OFS_COUNT, cnt);
         wr(`DMC_OFS_RUN_CTL, 1);
         xfer(1, 0);
         wr(`DMC_OFS_COUNT, cnt - 1);
         wr(`DMC_OFS_RUN_CTL, 1);
         xfer(0, 1);
         chk({active, esc_irq}, 2'b01, "size error stop");
         rd(`DMC_OFS_MODE_CTL);
         wr(`DMC_OFS_MODE_CTL, mw(0, a, m, 3'b110));
         chk(esc_irq, 0, "escape cleared");
      end
      $display("test size error done");
      wr(`DMC_OFS_MODE_CTL, mw(0, 0, 0, 3'b010));
      wr(`DMC_OFS_COUNT, 8);
      wr(`DMC_OFS_RUN_CTL, 1);
      @(posedge clk) esc <= 1;
      @(posedge clk) esc <= 0;
      @(negedge clk);
      chk({active, esc_irq}, 2'b01, "escape end");
      wr(`DMC_OFS_MODE_CTL, mw(0, 0, 0, 3'b000));
      chk(esc_irq, 0, "escape masked");
      wr(`DMC_OFS_MODE_CTL, mw(0, 0, 0, 3'b010));
      chk(esc_irq, 1, "escape flag kept");
      wr(`DMC_OFS_RUN_CTL, 1);
      chk(esc_irq, 0, "start clears escape");
      // The escape event lands at the same edge as a start write that clears the flag.
      fork
         wr(`DMC_OFS_RUN_CTL, 1);
         begin
            repeat (2) @(posedge clk);
            esc <= 1;
            @(posedge clk) esc <= 0;
         end
      join
      chk({active, esc_irq}, 2'b11, "set beats clear");
      $display("test escape done");
      complete_run;
   end
endmodule // dmc_channel_ctl_bench

// ===== tb/dmc_channel_ctl_monitor.sv
// Concurrent checks on the channel control block ports.
`timescale 1ns/1ns
module dmc_channel_ctl_monitor (
   input wire MCLK,
   input wire RST,
   input wire S_AXI_BVALID,
   input wire XFER_REQ,
   input wire ESC_EVENT,
   input wire CHAN_ACTIVE,
   input wire [1:0] ACC_SIZE,
   input wire [1:0] XFER_MODE,
   input wire XFER_ACK,
   input wire SIZE_ERR,
   input wire ESC_IRQ,
   input wire CNT_IRQ
);
   // One clock domain, so clocking and reset are given once.
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RST);

   a_cnt_irq_cause: assert property (
      $rose(CNT_IRQ) |-> XFER_ACK || $rose(S_AXI_BVALID))
      else $error("count interrupt rose without a cause");
   a_esc_irq_cause: assert property (
      $rose(ESC_IRQ) |-> SIZE_ERR || $rose(S_AXI_BVALID) || $past(ESC_EVENT))
      else $error("escape interrupt rose without a cause");
   a_cnt_irq_drop: assert property (
      $fell(CNT_IRQ) && !$past(RST) |-> $rose(S_AXI_BVALID))
      else $error("count interrupt fell without a write");
   a_esc_irq_drop: assert property (
      $fell(ESC_IRQ) && !$past(RST) |-> $rose(S_AXI_BVALID))
      else $error("escape interrupt fell without a write");
   a_req_answered: assert property (
      XFER_REQ && CHAN_ACTIVE |=> XFER_ACK ^ SIZE_ERR)
      else $error("request not answered by exactly one pulse");
   a_pulse_cause: assert property (
      (XFER_ACK || SIZE_ERR) |-> $past(XFER_REQ) && $past(CHAN_ACTIVE))
      else $error("pulse without an accepted request");
   a_err_stops: assert property (
      SIZE_ERR |-> !CHAN_ACTIVE)
      else $error("channel still active after size error");
   a_fields_steady: assert property (
      !$stable({ACC_SIZE, XFER_MODE}) && !$past(RST) |-> $rose(S_AXI_BVALID))
      else $error("mode fields changed without a write");
   a_stop_cause: assert property (
      $fell(CHAN_ACTIVE) && !$past(RST) |->
      XFER_ACK || SIZE_ERR || $rose(S_AXI_BVALID) || $past(ESC_EVENT))
      else $error("channel stopped without a cause");
endmodule // dmc_channel_ctl_monitor

bind dmc_channel_ctl dmc_channel_ctl_monitor u_mon (.MCLK(MCLK), .RST(RST),
   .S_AXI_BVALID(S_AXI_BVALID), .XFER_REQ(XFER_REQ), .ESC_EVENT(ESC_EVENT),
   .CHAN_ACTIVE(CHAN_ACTIVE), .ACC_SIZE(ACC_SIZE), .XFER_MODE(XFER_MODE),
   .XFER_ACK(XFER_ACK), .SIZE_ERR(SIZE_ERR), .ESC_IRQ(ESC_IRQ), .CNT_IRQ(CNT_IRQ));

// ===== verilog/dmc_channel_ctl.v
// DMA channel mode register slice with count-end and escape-end flags.
`timescale 1ns/1ns
`include "dmc_consts.vh"

module dmc_channel_ctl (
   input wire MCLK,
   input wire RST,
   input wire [7:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   output wire [1:0] S_AXI_BRESP,
   output wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [7:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   output wire [31:0] S_AXI_RDATA,
   output wire [1:0] S_AXI_RRESP,
   output wire S_AXI_RVALID,
   input wire S_AXI_RREADY,
   input wire XFER_REQ,
   input wire ESC_EVENT,
   output wire CHAN_ACTIVE,
   output wire [1:0] ACC_SIZE,
   output wire [1:0] XFER_MODE,
   output wire XFER_ACK,
   output wire SIZE_ERR,
   output wire ESC_IRQ,
   output wire CNT_IRQ
);

   reg aw_full_q;
   reg w_full_q;
   reg [7:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [1:0] rresp_q;
   reg [31:0] rdata_q;

   reg [1:0] acc_size_q;
   reg [1:0] mode_q;
   reg szerr_en_q;
   reg esc_en_q;
   reg cnt_en_q;
   reg cnt_flag_q;
   reg esc_flag_q;
   reg cnt_seen_q;
   reg esc_seen_q;
   reg active_q;
   reg [31:0] count_q;
   reg [15:0] block_q;
   reg xfer_ack_q;
   reg size_err_q;

   wire [31:0] mask;
   wire [31:0] mode_word;
   wire [31:0] run_word;
   wire wr_fire;
   wire wr_mode;
   wire wr_run;
   wire wr_count;
   wire wr_block;
   wire wr_hit;
   wire rd_fire;
   wire [31:0] mode_wv;
   wire [31:0] run_wv;
   wire [31:0] count_wv;
   wire [31:0] block_wv;
   wire [31:0] acc_bytes;
   wire [31:0] unit_amount;
   wire count_short;
   wire req_ok;
   wire size_err;
   wire step;
   wire [31:0] next_count;
   wire cnt_end;
   wire esc_end;
   wire sw_start;
   wire cnt_clr;
   wire esc_clr;
   reg [31:0] rd_mux;

   // Byte-lane mask built from the latched write strobes.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
         assign mask[gi*8+7:gi*8] = {8{w_strb_q[gi]}};
      end
   endgenerate

   // Readback words; bit ten and the low byte of the mode word are held at zero.
   assign mode_word = {14'h0000, esc_flag_q, cnt_flag_q, acc_size_q, mode_q,
                       szerr_en_q, 1'b0, esc_en_q, cnt_en_q, 8'h00};
   assign run_word = {31'h0000_0000, active_q};

   // Write address and data are parked separately, so either may come first.
   assign S_AXI_AWREADY = !aw_full_q && !bvalid_q;
   assign S_AXI_WREADY = !w_full_q && !bvalid_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = !rvalid_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RRESP = rresp_q;
   assign S_AXI_RDATA = rdata_q;

   assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
   assign wr_mode = wr_fire && (aw_addr_q == `DMC_OFS_MODE_CTL);
   assign wr_run = wr_fire && (aw_addr_q == `DMC_OFS_RUN_CTL);
   assign wr_count = wr_fire && (aw_addr_q == `DMC_OFS_COUNT);
   assign wr_block = wr_fire && (aw_addr_q == `DMC_OFS_BLOCK);
   assign wr_hit = wr_mode || wr_run || wr_count || wr_block;
   assign rd_fire = S_AXI_ARVALID && !rvalid_q;

   // Merged write values keep the lanes that the strobes leave alone.
   assign mode_wv = (mode_word & ~mask) | (w_data_q & mask);
   assign run_wv = (run_word & ~mask) | (w_data_q & mask);
   assign count_wv = (count_q & ~mask) | (w_data_q & mask);
   assign block_wv = ({16'h0000, block_q} & ~mask) | (w_data_q & mask);

   // One request moves one access unit, or one whole block in block mode.
   assign acc_bytes = 32'h0000_0001 << acc_size_q;
   assign unit_amount = (mode_q == `DMC_MODE_BLOCK) ?
                        ({16'h0000, block_q} << acc_size_q) : acc_bytes;
   assign count_short = count_q < unit_amount;

   // Transfer bookkeeping; requests on an idle channel are dropped.
   assign req_ok = XFER_REQ && active_q;
   assign size_err = req_ok && szerr_en_q && count_short;
   assign step = req_ok && !size_err;
   // Without the size check a short tail finishes the count instead.
   assign next_count = count_short ? 32'h0000_0000 : (count_q - unit_amount);
   assign cnt_end = step && (next_count == 32'h0000_0000);
   assign esc_end = size_err || (ESC_EVENT && active_q);

   // Software flag clears: a start, or a zero written after a one was read.
   assign sw_start = wr_run && run_wv[`DMC_BIT_ACTIVE];
   assign cnt_clr = sw_start ||
                    (wr_mode && cnt_seen_q && !mode_wv[`DMC_BIT_CNT_FLAG]);
   assign esc_clr = sw_start ||
                    (wr_mode && esc_seen_q && !mode_wv[`DMC_BIT_ESC_FLAG]);

   // Read multiplexer; unmapped addresses read as zero.
   always @* begin
      case (S_AXI_ARADDR)
         `DMC_OFS_MODE_CTL: rd_mux = mode_word;
         `DMC_OFS_RUN_CTL: rd_mux = run_word;
         `DMC_OFS_COUNT: rd_mux = count_q;
         `DMC_OFS_BLOCK: rd_mux = {16'h0000, block_q};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // AXI4-Lite write channel handshakes and response.
   always @(posedge MCLK) begin
      if (RST) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `DMC_RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= {S_AXI_AWADDR[7:2], 2'b00};
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_full_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
         end
         if (wr_fire) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `DMC_RESP_OKAY : `DMC_RESP_SLVERR;
         end else if (bvalid_q && S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel; data is registered for one cycle of latency.
   always @(posedge MCLK) begin
      if (RST) begin
         rvalid_q <= 1'b0;
         rresp_q <= `DMC_RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else if (rd_fire) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= (S_AXI_ARADDR[7:4] == 4'h0) ? `DMC_RESP_OKAY : `DMC_RESP_SLVERR;
      end else if (rvalid_q && S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
      end
   end

   // Read-of-one tracking; any write to the mode word consumes the permit.
   always @(posedge MCLK) begin
      if (RST) begin
         cnt_seen_q <= 1'b0;
         esc_seen_q <= 1'b0;
      end else begin
         if (wr_mode) begin
            cnt_seen_q <= 1'b0;
            esc_seen_q <= 1'b0;
         end
         if (rd_fire && (S_AXI_ARADDR == `DMC_OFS_MODE_CTL)) begin
            if (cnt_flag_q) begin
               cnt_seen_q <= 1'b1;
            end
            if (esc_flag_q) begin
               esc_seen_q <= 1'b1;
            end
         end
      end
   end

   // Mode fields; the value 11 is stored as written but never expected.
   always @(posedge MCLK) begin
      if (RST) begin
         acc_size_q <= `DMC_ACC_BYTE;
         mode_q <= `DMC_MODE_NORMAL;
         szerr_en_q <= 1'b0;
         esc_en_q <= 1'b0;
         cnt_en_q <= 1'b0;
         block_q <= `DMC_RST_BLOCK;
      end else begin
         if (wr_mode) begin
            acc_size_q <= mode_wv[`DMC_BIT_ACC_HI:`DMC_BIT_ACC_LO];
            mode_q <= mode_wv[`DMC_BIT_MODE_HI:`DMC_BIT_MODE_LO];
            szerr_en_q <= mode_wv[`DMC_BIT_SZERR_EN];
            esc_en_q <= mode_wv[`DMC_BIT_ESC_EN];
            cnt_en_q <= mode_wv[`DMC_BIT_CNT_EN];
         end
         if (wr_block) begin
            block_q <= block_wv[15:0];
         end
      end
   end

   // Flags: the hardware set is tested last so it beats any clear.
   always @(posedge MCLK) begin
      if (RST) begin
         cnt_flag_q <= 1'b0;
         esc_flag_q <= 1'b0;
      end else begin
         if (cnt_clr) begin
            cnt_flag_q <= 1'b0;
         end
         if (cnt_end) begin
            cnt_flag_q <= 1'b1;
         end
         if (esc_clr) begin
            esc_flag_q <= 1'b0;
         end
         if (esc_end) begin
            esc_flag_q <= 1'b1;
         end
      end
   end

   // Channel active bit and counter; a software write overrides the engine.
   always @(posedge MCLK) begin
      if (RST) begin
         active_q <= 1'b0;
         count_q <= `DMC_RST_COUNT;
         xfer_ack_q <= 1'b0;
         size_err_q <= 1'b0;
      end else begin
         xfer_ack_q <= step;
         size_err_q <= size_err;
         if (wr_run) begin
            active_q <= run_wv[`DMC_BIT_ACTIVE];
         end else if (esc_end || cnt_end) begin
            active_q <= 1'b0;
         end
         if (wr_count) begin
            count_q <= count_wv;
         end else if (step) begin
            count_q <= next_count;
         end
      end
   end

   // Interrupt requests follow flag and enable with no extra state.
   assign ESC_IRQ = esc_flag_q && esc_en_q;
   assign CNT_IRQ = cnt_flag_q && cnt_en_q;
   assign CHAN_ACTIVE = active_q;
   assign ACC_SIZE = acc_size_q;
   assign XFER_MODE = mode_q;
   assign XFER_ACK = xfer_ack_q;
   assign SIZE_ERR = size_err_q;

endmodule // dmc_channel_ctl

// ===== verilog/dmc_consts.vh
// Constants for the DMA channel mode and interrupt control slice.
`ifndef DMC_CONSTS_VH
`define DMC_CONSTS_VH

// Register byte offsets on the AXI4-Lite bus.
`define DMC_OFS_MODE_CTL 8'h00
`define DMC_OFS_RUN_CTL 8'h04
`define DMC_OFS_COUNT 8'h08
`define DMC_OFS_BLOCK 8'h0c

// Field positions inside the mode control word.
`define DMC_BIT_ESC_FLAG 17
`define DMC_BIT_CNT_FLAG 16
`define DMC_BIT_ACC_HI 15
`define DMC_BIT_ACC_LO 14
`define DMC_BIT_MODE_HI 13
`define DMC_BIT_MODE_LO 12
`define DMC_BIT_SZERR_EN 11
`define DMC_BIT_RSVD 10
`define DMC_BIT_ESC_EN 9
`define DMC_BIT_CNT_EN 8
// Channel active bit position inside the run control word.
`define DMC_BIT_ACTIVE 0

// Access size encodings.
`define DMC_ACC_BYTE 2'h0
`define DMC_ACC_WORD 2'h1
`define DMC_ACC_LONG 2'h2

// Transfer mode encodings.
`define DMC_MODE_NORMAL 2'h0
`define DMC_MODE_BLOCK 2'h1
`define DMC_MODE_REPEAT 2'h2

// Reset values.
`define DMC_RST_COUNT 32'h0000_0000
`define DMC_RST_BLOCK 16'h0001

// AXI response codes.
`define DMC_RESP_OKAY 2'h0
`define DMC_RESP_SLVERR 2'h2

`endif
